// >>> verilog/intc_pkg.sv
// Constants and carrier types for the vectored interrupt controller.
// Assumes an 8-bit CPU core on the same clock that owns the stack and PC.
// Operation
// - Each of the fifteen sources has its own enable bit in one of two registers.
// - Writing one to an enable bit enables that source; zero disables it.
// - Global enable flag blocks all requests when clear, passes enabled ones when set.
// - Reset clears both enable registers and the global enable flag.
// - Vector read gives highest-priority enabled pending vector; any vector write clears all pending; a source firing in that same cycle stays set.
// - One pending flip-flop per source, set when the source fires.
// - Pending stays set until serviced, reset, or vector register write.
// - Request reaches CPU only when source enable and global enable are set.
// - Masked-away sole pending still taken; empty vectoring yields vector zero.
// - Acknowledge runs a 13-cycle call pushing PC high, PC low, flags.
// - Flags register cleared after its copy is pushed, blocking further interrupts.
// - Return-from-interrupt restores flags, bringing back the saved global enable.
// - Of several pending sources, lowest priority number is serviced first.
// - Vectors four bytes apart, 0x0004 to 0x003C, in fixed source order.
// - No vector at or above the start of program memory.
// - Servicing loads the PC with the selected source's table address.
// - Both enable registers sit in bank 0 at consecutive addresses.
// - Vector register follows them, eight bits, reads zero after reset.
// - General enables: supply, analog columns 0-3, GPIO, sleep, bit 7 reserved.
// - Digital enables: basic blocks 0-3 in bits 0-3, comm blocks 4-7 above.
`default_nettype none

package intc_pkg;

    localparam int NUM_SRC = 15;

    // Bank 0 register addresses
    localparam logic [7:0] ADDR_GEN_EN = 8'he0;
    localparam logic [7:0] ADDR_DIG_EN = 8'he1;
    localparam logic [7:0] ADDR_VECTOR = 8'he2;

    // Reset values
    localparam logic [7:0] GEN_EN_RST = 8'h00;
    localparam logic [7:0] DIG_EN_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // Field positions
    localparam int GLOBAL_ENABLE_BIT = 0;
    localparam int GEN_SUPPLY_BIT = 0;
    localparam int GEN_ACOL_LSB = 1;
    localparam int GEN_GPIO_BIT = 5;
    localparam int GEN_SLEEP_BIT = 6;

    // Vector table layout
    localparam logic [7:0] VEC_STRIDE = 8'h04;
    localparam logic [15:0] PROG_START = 16'h0040;

    // Acknowledge call timing, counted from the first call cycle
    localparam logic [3:0] CALL_CYCLES = 4'hd;
    localparam logic [3:0] CALL_LAST = CALL_CYCLES - 4'h1;
    localparam logic [3:0] PUSH_PC_HI = 4'h0;
    localparam logic [3:0] PUSH_PC_LO = 4'h1;
    localparam logic [3:0] PUSH_FLAGS = 4'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALL = 2'b10
    } ack_state_e;

    // Register access from the CPU core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // One byte pushed onto the program stack
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } stack_push_s;

endpackage

`default_nettype wire

// >>> verilog/vectored_intc.sv
// Fifteen-source fixed-priority vectored interrupt controller.
// Assumes the CPU core stalls while ACK_BUSY is high and performs the
// pushes and the PC load that this block strobes; inputs are synchronous.
`timescale 1ns/10ps
`default_nettype none

module vectored_intc (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [14:0] SRC_EVENT,
    input wire intc_pkg::reg_req_s REG_REQ,
    output logic [7:0] REG_RDATA,
    input wire logic FLAGS_WR,
    input wire logic [7:0] FLAGS_WDATA,
    input wire logic RETURN_FROM_INTERRUPT,
    input wire logic [7:0] RETURN_FLAGS,
    input wire logic [15:0] PROGRAM_COUNTER_REGISTER,
    input wire logic BOUNDARY,
    output logic IRQ,
    output logic ACK_BUSY,
    output intc_pkg::stack_push_s STACK_PUSH,
    output logic PC_LOAD,
    output logic [15:0] PC_VECTOR,
    output logic [7:0] FLAGS
);

    intc_pkg::ack_state_e state_ff;
    intc_pkg::ack_state_e nxt_state;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] gen_en_ff;
    logic [7:0] dig_en_ff;
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [14:0] pend_ff;
    logic [14:0] nxt_pend;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    intc_pkg::stack_push_s push_ff;
    intc_pkg::stack_push_s nxt_push;
    logic pc_load_ff;
    logic [15:0] pc_vec_ff;

    // Lowest index wins; zero when nothing is active
    function automatic logic [7:0] vec_of(input logic [14:0] act);
        logic [7:0] v;
        v = 8'h00;
        for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (act[i]) begin
                v = intc_pkg::VEC_STRIDE * 8'(i + 1);
            end
        end
        return v;
    endfunction

    // Source order: supply, digital 0-7, analog 0-3, GPIO, sleep
    wire [14:0] en_vec = {gen_en_ff[intc_pkg::GEN_SLEEP_BIT],
                          gen_en_ff[intc_pkg::GEN_GPIO_BIT],
                          gen_en_ff[intc_pkg::GEN_ACOL_LSB +: 4],
                          dig_en_ff,
                          gen_en_ff[intc_pkg::GEN_SUPPLY_BIT]};
    wire [14:0] act = pend_ff & en_vec;
    wire global_enable_flag = flags_ff[intc_pkg::GLOBAL_ENABLE_BIT];
    wire [14:0] win = act & (~act + 15'h0001);
    wire [7:0] vec_now = vec_of(act);

    // Register decode
    wire wr_gen = REG_REQ.wr && (REG_REQ.addr == intc_pkg::ADDR_GEN_EN);
    wire wr_dig = REG_REQ.wr && (REG_REQ.addr == intc_pkg::ADDR_DIG_EN);
    wire wr_vec = REG_REQ.wr && (REG_REQ.addr == intc_pkg::ADDR_VECTOR);
    wire in_idle = (state_ff == intc_pkg::ST_IDLE);
    wire in_call = (state_ff == intc_pkg::ST_CALL);
    wire start = in_idle && IRQ && BOUNDARY;
    wire vec_step = in_call && (cnt_ff == intc_pkg::CALL_LAST);
    // Winner is picked at vectoring, so a mask cleared meanwhile gives zero
    wire [14:0] ack_clr = vec_step ? win : 15'h0000;

    // Request needs both the source enable and the global flag
    assign IRQ = global_enable_flag && (|act);
    assign ACK_BUSY = in_call;
    assign REG_RDATA = rdata_ff;
    assign STACK_PUSH = push_ff;
    assign PC_LOAD = pc_load_ff;
    assign PC_VECTOR = pc_vec_ff;
    assign FLAGS = flags_ff;

    // Pending flops; a new event beats any clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < intc_pkg::NUM_SRC; g++) begin : g_pend
            assign nxt_pend[g] = SRC_EVENT[g] ||
                (pend_ff[g] && !wr_vec && !ack_clr[g]);
            always_ff @(posedge CLOCK) begin
                if (RST) begin
                    pend_ff[g] <= 1'b0;
                end else begin
                    pend_ff[g] <= nxt_pend[g];
                end
            end
        end
    endgenerate

    // Enable registers written by the core
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            gen_en_ff <= intc_pkg::GEN_EN_RST;
            dig_en_ff <= intc_pkg::DIG_EN_RST;
        end else begin
            if (wr_gen) begin
                gen_en_ff <= REG_REQ.wdata;
            end
            if (wr_dig) begin
                dig_en_ff <= REG_REQ.wdata;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                intc_pkg::ADDR_GEN_EN: nxt_rdata = gen_en_ff;
                intc_pkg::ADDR_DIG_EN: nxt_rdata = dig_en_ff;
                intc_pkg::ADDR_VECTOR: nxt_rdata = vec_now;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Acknowledge sequencer: a fixed-length call the core waits out
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            intc_pkg::ST_IDLE: begin
                nxt_cnt = 4'h0;
                if (start) begin
                    nxt_state = intc_pkg::ST_CALL;
                end
            end
            intc_pkg::ST_CALL: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (vec_step) begin
                    nxt_state = intc_pkg::ST_IDLE;
                    nxt_cnt = 4'h0;
                end
            end
            default: begin
                nxt_state = intc_pkg::ST_IDLE;
                nxt_cnt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_ff <= intc_pkg::ST_IDLE;
            cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Stack pushes: PC high, PC low, then flags
    always_comb begin
        nxt_push = '0;
        if (in_call) begin
            case (cnt_ff)
                intc_pkg::PUSH_PC_HI: nxt_push = {1'b1, PROGRAM_COUNTER_REGISTER[15:8]};
                intc_pkg::PUSH_PC_LO: nxt_push = {1'b1, PROGRAM_COUNTER_REGISTER[7:0]};
                intc_pkg::PUSH_FLAGS: nxt_push = {1'b1, flags_ff};
                default: nxt_push = '0;
            endcase
        end
    end

    // Flags: clearing during the call outranks core writes and returns
    always_comb begin
        nxt_flags = flags_ff;
        if (in_call && cnt_ff == intc_pkg::PUSH_FLAGS) begin
            nxt_flags = 8'h00;
        end else if (RETURN_FROM_INTERRUPT) begin
            nxt_flags = RETURN_FLAGS;
        end else if (FLAGS_WR) begin
            nxt_flags = FLAGS_WDATA;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            flags_ff <= intc_pkg::FLAGS_RST;
            push_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
            push_ff <= nxt_push;
        end
    end

    // Vector load at the end of the call; high byte always zero
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pc_load_ff <= 1'b0;
            pc_vec_ff <= 16'h0000;
        end else begin
            pc_load_ff <= vec_step;
            if (vec_step) begin
                pc_vec_ff <= {8'h00, vec_now};
            end
        end
    end

    // Checks
    sequence s_push3;
        STACK_PUSH.valid ##1 STACK_PUSH.valid ##1 STACK_PUSH.valid;
    endsequence

    sequence s_call_end;
        ##12 ACK_BUSY ##1 !ACK_BUSY;
    endsequence

    AST_RESET_CLEARS: assert property (@(posedge CLOCK)
        RST |=> (gen_en_ff == 8'h00) && (dig_en_ff == 8'h00) && !FLAGS[0])
        else $error("Reset left enables or global flag set");

    AST_ENABLE_WRITE: assert property (@(posedge CLOCK) disable iff (RST)
        wr_gen |=> gen_en_ff == $past(REG_REQ.wdata))
        else $error("General enable write not stored");

    // Enables regathered bit by bit, so a wrong source map in en_vec shows up
    AST_IRQ_GATED: assert property (@(posedge CLOCK) disable iff (RST)
        IRQ |-> FLAGS[0] && ((pend_ff & {gen_en_ff[6], gen_en_ff[5], gen_en_ff[4:1],
            dig_en_ff, gen_en_ff[0]}) != 15'h0000))
        else $error("Request without enable");

    AST_EVENT_SETS: assert property (@(posedge CLOCK) disable iff (RST)
        (SRC_EVENT != 15'h0000) |=> ((pend_ff & $past(SRC_EVENT)) == $past(SRC_EVENT)))
        else $error("Event did not set pending");

    AST_PEND_HOLDS: assert property (@(posedge CLOCK) disable iff (RST)
        (!wr_vec && !vec_step) |=> ((pend_ff & $past(pend_ff)) == $past(pend_ff)))
        else $error("Pending lost without service");

    AST_VEC_WRITE_CLEARS: assert property (@(posedge CLOCK) disable iff (RST)
        (wr_vec && SRC_EVENT == 15'h0000) |=> pend_ff == 15'h0000)
        else $error("Vector write did not clear pending");

    AST_CALL_LENGTH: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ACK_BUSY) |-> s_call_end)
        else $error("Acknowledge call not 13 cycles");

    AST_PUSH_ORDER: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ACK_BUSY) |=> s_push3 ##1 !STACK_PUSH.valid)
        else $error("Stack pushes not three in a row");

    AST_FLAGS_CLEARED: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ACK_BUSY) |-> ##3 (FLAGS == 8'h00) && !IRQ)
        else $error("Flags not cleared after push");

    AST_RETURN_RESTORE: assert property (@(posedge CLOCK) disable iff (RST)
        (RETURN_FROM_INTERRUPT && !ACK_BUSY) |=> FLAGS == $past(RETURN_FLAGS))
        else $error("Return did not restore flags");

    AST_VECTOR_RANGE: assert property (@(posedge CLOCK) disable iff (RST)
        PC_LOAD |-> (PC_VECTOR < intc_pkg::PROG_START) && (PC_VECTOR[1:0] == 2'b00))
        else $error("Vector outside table");

    AST_ACK_CLEARS_ONE: assert property (@(posedge CLOCK) disable iff (RST)
        (vec_step && !wr_vec && SRC_EVENT == 15'h0000) |=> pend_ff == ($past(pend_ff) & ~$past(win)))
        else $error("Acknowledge cleared wrong pending");

    // Remaining checks; table points written out so they do not lean on vec_of
    AST_DIG_WRITE: assert property (@(posedge CLOCK) disable iff (RST)
        wr_dig |=> dig_en_ff == $past(REG_REQ.wdata))
        else $error("Digital enable write not stored");

    AST_TOP_PRIORITY: assert property (@(posedge CLOCK) disable iff (RST)
        (REG_REQ.rd && (REG_REQ.addr == intc_pkg::ADDR_VECTOR) && act[0]) |=> REG_RDATA == 8'h04)
        else $error("Supply source not read as top vector");

    AST_UNMAPPED_READ: assert property (@(posedge CLOCK) disable iff (RST)
        (REG_REQ.rd && (REG_REQ.addr > intc_pkg::ADDR_VECTOR)) |=> REG_RDATA == 8'h00)
        else $error("Unmapped address read nonzero");

    AST_START_NEEDS_IRQ: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ACK_BUSY) |-> $past(IRQ) && $past(BOUNDARY))
        else $error("Acknowledge without request");

    AST_THIRD_SOURCE_VECTOR: assert property (@(posedge CLOCK) disable iff (RST)
        (vec_step && (act[2:0] == 3'b100)) |=> PC_LOAD && (PC_VECTOR == 16'h000c))
        else $error("Third source not loaded at its table address");

    AST_EMPTY_VECTOR: assert property (@(posedge CLOCK) disable iff (RST)
        (vec_step && (act == 15'h0000)) |=> PC_LOAD && (PC_VECTOR == 16'h0000))
        else $error("Empty vectoring did not load zero");

endmodule // vectored_intc

`default_nettype wire

// >>> verif/cpu_core_model.sv
// CPU core stand-in: offers instruction boundaries, counts the call.
// Assumes the controller on the same clock, stalls core while busy.
`timescale 1ns/10ps
`default_nettype none

module cpu_core_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic take,
    input wire logic ack_busy,
    input wire intc_pkg::stack_push_s stack_push,
    output logic boundary,
    output logic [15:0] program_counter_register,
    output logic [7:0] busy_cnt,
    output logic [23:0] pushed
);
    // Fixed PC keeps the stacked bytes predictable
    assign program_counter_register = 16'hc35a;
    // Core is stalled during the call, so no boundary then
    assign boundary = take & ~ack_busy;

    // Busy length and the last three stacked bytes
    always_ff @(posedge clock) begin
        if (rst || !take) begin
            busy_cnt <= 8'h00;
        end else if (ack_busy) begin
            busy_cnt <= busy_cnt + 8'h01;
        end
        if (stack_push.valid) begin
            pushed <= {pushed[15:0], stack_push.data};
        end
    end
endmodule // cpu_core_model

`default_nettype wire

// >>> verif/priority_vectored_interrupt_controller_tb.sv
// Testbench for the vectored interrupt controller: register calls,
// source events and acknowledge calls against a core model.
`timescale 1ns/10ps
`default_nettype none

module priority_vectored_interrupt_controller_tb;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic [14:0] SRC_EVENT = 15'h0000;
    intc_pkg::reg_req_s REG_REQ = '0;
    logic FLAGS_WR = 1'b0;
    logic RETURN_FROM_INTERRUPT = 1'b0;
    logic [7:0] FLAGS_WDATA = 8'h00;
    logic [7:0] RETURN_FLAGS = 8'h00;
    logic take = 1'b0;
    logic [7:0] REG_RDATA, FLAGS, busy_cnt, rd;
    logic IRQ, ACK_BUSY, PC_LOAD, BOUNDARY;
    logic [15:0] PC_VECTOR, PROGRAM_COUNTER_REGISTER, vec;
    logic [23:0] pushed;
    intc_pkg::stack_push_s STACK_PUSH;
    int n_errors = 0;
    int num_checks = 0;

    always #20 CLOCK = ~CLOCK;

    vectored_intc i_vectored_intc (.CLOCK(CLOCK), .RST(RST), .SRC_EVENT(SRC_EVENT),
        .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .FLAGS_WR(FLAGS_WR),
        .FLAGS_WDATA(FLAGS_WDATA), .RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT),
        .RETURN_FLAGS(RETURN_FLAGS), .PROGRAM_COUNTER_REGISTER(PROGRAM_COUNTER_REGISTER),
        .BOUNDARY(BOUNDARY), .IRQ(IRQ), .ACK_BUSY(ACK_BUSY), .STACK_PUSH(STACK_PUSH),
        .PC_LOAD(PC_LOAD), .PC_VECTOR(PC_VECTOR), .FLAGS(FLAGS));
    cpu_core_model i_cpu_core_model (.clock(CLOCK), .rst(RST), .take(take),
        .ack_busy(ACK_BUSY), .stack_push(STACK_PUSH), .boundary(BOUNDARY),
        .program_counter_register(PROGRAM_COUNTER_REGISTER), .busy_cnt(busy_cnt),
        .pushed(pushed));

    task automatic report_and_stop();
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    // One-cycle pulses; each task ends just after the edge that took it
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLOCK) REG_REQ <= '{1'b1, 1'b0, a, d};
        @(posedge CLOCK) REG_REQ <= '0;
        #1;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLOCK) REG_REQ <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge CLOCK) REG_REQ <= '0;
        #1 d = REG_RDATA;
    endtask

    task automatic pulse(input logic [14:0] s);
        @(posedge CLOCK) SRC_EVENT <= s;
        @(posedge CLOCK) SRC_EVENT <= 15'h0000;
        #1;
    endtask

    // Flags write by the core, or restore on return
    task automatic flag_op(input logic ret, input logic [7:0] d);
        @(posedge CLOCK) begin
            FLAGS_WR <= ~ret;
            RETURN_FROM_INTERRUPT <= ret;
            FLAGS_WDATA <= d;
            RETURN_FLAGS <= d;
        end
        @(posedge CLOCK) begin
            FLAGS_WR <= 1'b0;
            RETURN_FROM_INTERRUPT <= 1'b0;
        end
        #1;
    endtask

    // Global disable around the enable write avoids a zero-vector entry
    task automatic guarded_enable_write(input logic [7:0] a, input logic [7:0] d);
        flag_op(1'b0, 8'h00);
        reg_wr(a, d);
        flag_op(1'b0, 8'h01);
    endtask

    // Offer a boundary and wait, bounded, for the vector load
    task automatic ack(output logic [15:0] v);
        int i;
        @(posedge CLOCK) take <= 1'b1;
        for (i = 0; i < 40 && PC_LOAD !== 1'b1; i++) begin
            @(posedge CLOCK);
            #1;
        end
        if (i == 40) begin
            n_errors++;
            report_and_stop();
        end
        v = PC_VECTOR;
        chk(busy_cnt, 8'h0d);
        @(posedge CLOCK) take <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (8) @(posedge CLOCK);
        RST <= 1'b0;
        #1;
        reg_rd(intc_pkg::ADDR_GEN_EN, rd); chk(rd, 8'h00);
        reg_rd(intc_pkg::ADDR_DIG_EN, rd); chk(rd, 8'h00);
        reg_rd(intc_pkg::ADDR_VECTOR, rd); chk(rd, 8'h00);
        chk(FLAGS, 8'h00);
        reg_rd(8'he3, rd); chk(rd, 8'h00);
        // Masked pending gives no vector but stays pending
        pulse(15'h0001); reg_rd(intc_pkg::ADDR_VECTOR, rd); chk(rd, 8'h00);
        reg_wr(intc_pkg::ADDR_GEN_EN, 8'hff); reg_wr(intc_pkg::ADDR_DIG_EN, 8'ha5);
        reg_wr(8'he5, 8'h77);
        reg_rd(intc_pkg::ADDR_GEN_EN, rd); chk(rd, 8'hff);
        reg_rd(intc_pkg::ADDR_DIG_EN, rd); chk(rd, 8'ha5);
        reg_rd(intc_pkg::ADDR_VECTOR, rd); chk(rd, 8'h04);
        chk(IRQ, 1'b0);
        reg_wr(intc_pkg::ADDR_DIG_EN, 8'hff);
        // Every source alone, then cleared by a vector write
        for (int k = 0; k < 15; k++) begin
            reg_wr(intc_pkg::ADDR_VECTOR, 8'h5a);
            reg_rd(intc_pkg::ADDR_VECTOR, rd); chk(rd, 8'h00);
            // GPIO pin and column source setup assumed done outside the block
            pulse(15'h0001 << k);
            reg_rd(intc_pkg::ADDR_VECTOR, rd); chk(rd, 8'((k + 1) * 4));
        end
        reg_wr(intc_pkg::ADDR_VECTOR, 8'h00);
        pulse(15'h0420); reg_rd(intc_pkg::ADDR_VECTOR, rd); chk(rd, 8'h18);
        reg_wr(intc_pkg::ADDR_VECTOR, 8'h00);
        // Acknowledge with two pending, then a nested second one
        pulse(15'h0024); flag_op(1'b0, 8'h01); chk(IRQ, 1'b1);
        ack(vec); chk(vec, 16'h000c);
        chk(pushed, 24'hc35a01);
        chk(FLAGS, 8'h00); chk(IRQ, 1'b0);
        reg_rd(intc_pkg::ADDR_VECTOR, rd); chk(rd, 8'h18);
        flag_op(1'b0, 8'h01);
        ack(vec); chk(vec, 16'h0018);
        flag_op(1'b1, 8'h01); chk(FLAGS, 8'h01); chk(IRQ, 1'b0);
        // Sole pending masked during the call gives vector zero
        pulse(15'h0001);
        fork
            ack(vec);
            begin
                repeat (4) @(posedge CLOCK);
                reg_wr(intc_pkg::ADDR_GEN_EN, 8'h00);
            end
        join
        chk(vec, 16'h0000);
        // Core sits at a boundary throughout, so a request leaking past the guard is taken
        reg_wr(intc_pkg::ADDR_GEN_EN, 8'hff); pulse(15'h0001);
        @(posedge CLOCK) take <= 1'b1;
        guarded_enable_write(intc_pkg::ADDR_GEN_EN, 8'h00);
        chk(IRQ, 1'b0); chk(ACK_BUSY, 1'b0); chk(busy_cnt, 8'h00);
        @(posedge CLOCK) take <= 1'b0;
        // Second reset in mid-run clears enables, flags and pending
        @(posedge CLOCK) RST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        #1;
        chk(FLAGS, 8'h00);
        reg_rd(intc_pkg::ADDR_GEN_EN, rd); chk(rd, 8'h00);
        reg_wr(intc_pkg::ADDR_GEN_EN, 8'hff);
        reg_rd(intc_pkg::ADDR_VECTOR, rd); chk(rd, 8'h00);
        report_and_stop();
    end
endmodule // priority_vectored_interrupt_controller_tb

`default_nettype wire
